// ===== fcl_pkg.sv
package fcl_pkg;

    // ==========================================================
    // Register map (byte addresses, one word each)
    localparam logic [11:0] FCL_ADDR_CLKDIV = 12'h000;
    localparam logic [11:0] FCL_ADDR_STAT   = 12'h004;
    localparam logic [11:0] FCL_ADDR_INDEX  = 12'h008;
    localparam logic [11:0] FCL_ADDR_PARAM  = 12'h00c;
    localparam logic [11:0] FCL_ADDR_MODE   = 12'h010;
    localparam logic [11:0] FCL_ADDR_PROT   = 12'h014;

    // ==========================================================
    // Field positions
    localparam int FCL_DIVLD_BIT  = 7;
    localparam int FCL_DIVLK_BIT  = 6;
    localparam int FCL_COMMAND_COMPLETE_FLAG_BIT   = 7;
    localparam int FCL_ACCESS_ERROR_FLAG_BIT = 5;
    localparam int FCL_PROTECTION_VIOLATION_FLAG_BIT = 4;
    localparam int FCL_MGS1_BIT   = 1;
    localparam int FCL_MGS0_BIT   = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  FCL_CLKDIV_RST = 8'h00;
    localparam logic [15:0] FCL_PARAM_RST  = 16'h0000;
    localparam logic [17:0] FCL_PROT_RST   = 18'h00000;

    // ==========================================================
    // Parameter indices and command codes
    localparam logic [2:0] FCL_IDX_CMD   = 3'h0;
    localparam logic [2:0] FCL_IDX_ADDR  = 3'h1;
    localparam logic [2:0] FCL_IDX_LAST  = 3'h5;
    localparam logic [7:0] FCL_CMD_PROG  = 8'h06;
    localparam logic [7:0] FCL_CMD_ONCE  = 8'h07;
    localparam logic [15:0] FCL_ONCE_MAX = 16'h0007;
    localparam int FCL_ONCE_PHRASES      = 8;

    // Valid program flash window (global address)
    localparam logic [17:0] FCL_PFLASH_LO = 18'h30000;
    localparam logic [17:0] FCL_PFLASH_HI = 18'h3ffff;

    // Array timing in cycles
    localparam int FCL_OP_CYCLES = 16;

    typedef enum logic [2:0] {
        FCL_IDLE   = 3'b000,
        FCL_CHECK  = 3'b001,
        FCL_BLANK  = 3'b010,
        FCL_PROG   = 3'b011,
        FCL_VERIFY = 3'b100,
        FCL_DONE   = 3'b101
    } fcl_state_t;

    // Request to array
    typedef struct packed {
        logic        start;
        logic        once;
        logic [17:0] addr;
        logic [63:0] data;
    } fcl_req_t;

    // Result from array
    typedef struct packed {
        logic done;
        logic verr;
        logic vunc;
    } fcl_rsp_t;

endpackage

// ===== fcl_array_op.sv
`timescale 1ns/1ps
module fcl_array_op (
    input  wire logic            sys_clk_in,   // Bus clock
    input  wire logic            rst_in,       // Sync reset
    input  wire fcl_pkg::fcl_req_t req_in,     // Operation request
    input  wire logic            ver_err_in,   // Verify error from array
    input  wire logic            ver_unc_in,   // Uncorrectable from array
    output fcl_pkg::fcl_rsp_t    rsp_out       // Operation result
);
    import fcl_pkg::*;

    logic [4:0] cnt;
    logic       busy;

    // ==========================================================
    // Fixed-length array operation timer
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            busy    <= 1'b0;
            cnt     <= 5'h00;
            rsp_out <= '0;
        end else begin
            rsp_out.done <= 1'b0;
            if (req_in.start && !busy) begin
                busy <= 1'b1;
                cnt  <= 5'(FCL_OP_CYCLES - 1);
            end else if (busy) begin
                if (cnt == 5'h00) begin
                    busy         <= 1'b0;
                    rsp_out.done <= 1'b1;
                    rsp_out.verr <= ver_err_in;
                    rsp_out.vunc <= ver_unc_in;
                end else begin
                    cnt <= cnt - 5'h01;
                end
            end
        end
    end
endmodule

// ===== fcl_launcher.sv
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - Divider-loaded bit sets on first write
// - Normal mode: bit 6 write-once, locks divider
// - Special mode: bits 6-0 freely writable
// - Writing one to complete flag launches
// - Parameters locked while command runs
// - Results readable after flag returns
// - Indices 110,111 ignore writes, read zero
// - Index 0 command, address, four data
// - Program: index must be 101
// - Program: command must suit mode
// - Program: global address must be valid
// - Program: address must be phrase aligned
// - Program: protected address sets violation
// - Any verify error sets bit one
// - Uncorrectable verify error sets bit zero
// - Once region: 64 bytes, 8 phrases
// - Once: blank check, program, verify
// - Programmed once phrase refused
// - Flash reads invalid during once
module fcl_launcher (
    input  wire logic        sys_clk_in,     // Bus clock
    input  wire logic        rst_in,         // Sync reset, active high
    input  wire logic        psel,           // APB select
    input  wire logic        penable,        // APB enable
    input  wire logic        pwrite,         // APB direction
    input  wire logic [11:0] paddr,          // APB address
    input  wire logic [31:0] pwdata,         // APB write data
    output logic             pready,         // APB ready
    output logic [31:0]      prdata,         // APB read data
    output logic             pslverr,        // APB error
    input  wire logic        ver_err_in,     // Array verify error
    input  wire logic        ver_unc_in,     // Array uncorrectable error
    output fcl_pkg::fcl_req_t arr_req_out,   // Array request
    output logic             read_inv_out,   // Flash reads invalid
    output logic [5:0]       div_out         // Divider value
);
    import fcl_pkg::*;

    // ==========================================================
    // Storage
    logic [7:0]              clkdiv;
    logic [2:0]              pindex;
    logic [15:0]             param [0:5];
    logic                    command_complete_flag;
    logic                    access_error_flag;
    logic                    protection_violation_flag;
    logic                    mgs1;
    logic                    mgs0;
    logic                    special;
    logic [17:0]             prot_base;
    logic [FCL_ONCE_PHRASES-1:0] once_used;
    fcl_state_t              state;
    fcl_state_t              next_state;
    fcl_rsp_t                rsp;
    logic                    wr;
    logic                    rd;
    logic                    launch;
    logic                    op_busy;
    logic [7:0]              cmd;
    logic [17:0]             gaddr;
    logic                    bad;
    logic                    prot_hit;
    logic [2:0]              once_idx;
    logic                    mapped;
    logic                    wr_clkdiv;
    logic                    wr_stat;
    logic                    wr_index;
    logic                    wr_param;
    logic                    wr_mode;
    logic                    wr_prot;

    function automatic logic addr_valid(input logic [17:0] a);
        return (a >= FCL_PFLASH_LO) && (a <= FCL_PFLASH_HI);
    endfunction

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !pwrite;
    assign pready  = 1'b1;
    assign op_busy = (state != FCL_IDLE);
    assign cmd     = param[FCL_IDX_CMD][15:8];
    assign gaddr   = {param[FCL_IDX_CMD][1:0], param[FCL_IDX_ADDR]};
    assign once_idx = param[FCL_IDX_ADDR][2:0];
    assign div_out = clkdiv[5:0];
    assign mapped  = (paddr == FCL_ADDR_CLKDIV) || (paddr == FCL_ADDR_STAT) ||
                     (paddr == FCL_ADDR_INDEX) || (paddr == FCL_ADDR_PARAM) ||
                     (paddr == FCL_ADDR_MODE) || (paddr == FCL_ADDR_PROT);
    assign pslverr = psel && penable && !mapped;

    // One strobe per word, shared by the flags and the registers below
    assign wr_clkdiv = wr && (paddr == FCL_ADDR_CLKDIV);
    assign wr_stat   = wr && (paddr == FCL_ADDR_STAT);
    assign wr_index  = wr && (paddr == FCL_ADDR_INDEX);
    assign wr_param  = wr && (paddr == FCL_ADDR_PARAM);
    assign wr_mode   = wr && (paddr == FCL_ADDR_MODE);
    assign wr_prot   = wr && (paddr == FCL_ADDR_PROT);

    // Launch needs a write of one to the flag while idle
    assign launch = wr_stat && pwdata[FCL_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag && !op_busy;

    // ==========================================================
    // Launch checks
    assign prot_hit = (gaddr >= prot_base);
    always_comb begin
        bad = 1'b0;
        if (cmd == FCL_CMD_PROG) begin
            if (pindex != FCL_IDX_LAST)    bad = 1'b1;
            if (special)                   bad = 1'b1;
            if (!addr_valid(gaddr))        bad = 1'b1;
            if (gaddr[2:0] != 3'h0)        bad = 1'b1;
        end else if (cmd == FCL_CMD_ONCE) begin
            if (pindex != FCL_IDX_LAST)    bad = 1'b1;
            if (param[FCL_IDX_ADDR] > FCL_ONCE_MAX) bad = 1'b1;
        end else begin
            bad = 1'b1;
        end
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            FCL_IDLE:   if (launch) next_state = FCL_CHECK;
            FCL_CHECK: begin
                if (access_error_flag || protection_violation_flag)
                    next_state = FCL_DONE;
                else if (cmd == FCL_CMD_ONCE)
                    next_state = FCL_BLANK;
                else
                    next_state = FCL_PROG;
            end
            FCL_BLANK:  next_state = once_used[once_idx] ? FCL_DONE : FCL_PROG;
            FCL_PROG:   if (rsp.done) next_state = FCL_VERIFY;
            FCL_VERIFY: next_state = FCL_DONE;
            FCL_DONE:   next_state = FCL_IDLE;
            default:    next_state = FCL_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) state <= FCL_IDLE;
        else        state <= next_state;
    end

    // Array request pulse on entering program
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            arr_req_out <= '0;
        end else begin
            arr_req_out.start <= (next_state == FCL_PROG) && (state != FCL_PROG);
            arr_req_out.once  <= (cmd == FCL_CMD_ONCE);
            arr_req_out.addr  <= gaddr;
            arr_req_out.data  <= {param[5], param[4], param[3], param[2]};
        end
    end

    // Registered so the flash read path sees a clean level
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            read_inv_out <= 1'b0;
        end else begin
            read_inv_out <= (next_state != FCL_IDLE) && (cmd == FCL_CMD_ONCE);
        end
    end

    fcl_array_op u_op (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .req_in     (arr_req_out),
        .ver_err_in (ver_err_in),
        .ver_unc_in (ver_unc_in),
        .rsp_out    (rsp)
    );

    // ==========================================================
    // Completion flag and error flags
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            command_complete_flag <= 1'b1;
        end else if (launch) begin
            command_complete_flag <= 1'b0;
        end else if (state == FCL_DONE) begin
            command_complete_flag <= 1'b1;
        end
    end

    // Error flags: cleared by writing one while idle; a new launch reloads them from the launch checks
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            access_error_flag <= 1'b0;
            protection_violation_flag <= 1'b0;
        end else if (launch) begin
            access_error_flag <= bad;
            protection_violation_flag <= (cmd == FCL_CMD_PROG) && prot_hit;
        end else if (state == FCL_BLANK && once_used[once_idx]) begin
            access_error_flag <= 1'b1;
        end else if (wr_stat && !op_busy) begin
            if (pwdata[FCL_ACCESS_ERROR_FLAG_BIT]) access_error_flag <= 1'b0;
            if (pwdata[FCL_PROTECTION_VIOLATION_FLAG_BIT]) protection_violation_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            mgs1 <= 1'b0;
            mgs0 <= 1'b0;
        end else if (launch) begin
            mgs1 <= 1'b0;
            mgs0 <= 1'b0;
        end else if (rsp.done) begin
            mgs1 <= rsp.verr || rsp.vunc;
            mgs0 <= rsp.vunc;
        end
    end

    // Reserved once phrases are marked on completion
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            once_used <= '0;
        end else if (state == FCL_VERIFY && cmd == FCL_CMD_ONCE) begin
            once_used[once_idx] <= 1'b1;
        end
    end

    // ==========================================================
    // Divider register
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            clkdiv <= FCL_CLKDIV_RST;
        end else if (wr_clkdiv && !op_busy) begin
            clkdiv[FCL_DIVLD_BIT] <= 1'b1;
            if (special) begin
                clkdiv[6:0] <= pwdata[6:0];
            end else if (!clkdiv[FCL_DIVLK_BIT]) begin
                clkdiv[6:0] <= pwdata[6:0];
            end
        end
    end

    // ==========================================================
    // Index, mode, protection, parameter array
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pindex    <= 3'h0;
            special   <= 1'b0;
            prot_base <= FCL_PROT_RST;
        end else if (!op_busy) begin
            if (wr_index) pindex <= pwdata[2:0];
            if (wr_mode)  special <= pwdata[0];
            if (wr_prot)  prot_base <= pwdata[17:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 6; i++) begin
                param[i] <= FCL_PARAM_RST;
            end
        end else if (wr_param && command_complete_flag && !op_busy
                     && pindex <= FCL_IDX_LAST) begin
            param[pindex] <= pwdata[15:0];
        end
    end

    // ==========================================================
    // Read data
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            prdata <= 32'h00000000;
        end else if (rd && !penable) begin
            unique case (paddr)
                FCL_ADDR_CLKDIV: prdata <= {24'h000000, clkdiv};
                FCL_ADDR_STAT:   prdata <= {24'h000000, command_complete_flag, 1'b0, access_error_flag, protection_violation_flag,
                                            2'b00, mgs1, mgs0};
                FCL_ADDR_INDEX:  prdata <= {29'h00000000, pindex};
                FCL_ADDR_PARAM:  prdata <= (pindex > FCL_IDX_LAST || !command_complete_flag) ?
                                            32'h00000000 :
                                            {16'h0000, param[pindex]};
                FCL_ADDR_MODE:   prdata <= {31'h00000000, special};
                FCL_ADDR_PROT:   prdata <= {14'h0000, prot_base};
                default:         prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// ===== fcl_launcher_props.sv
`timescale 1ns/1ps
module fcl_launcher_props
    import fcl_pkg::*;
(
    input  wire logic              sys_clk_in,   // Bus clock
    input  wire logic              rst_in,       // Sync reset
    input  wire logic              psel,         // APB select
    input  wire logic              penable,      // APB enable
    input  wire logic              pwrite,       // APB direction
    input  wire logic [11:0]       paddr,        // APB address
    input  wire logic              pready,       // APB ready
    input  wire logic [31:0]       prdata,       // APB read data
    input  wire logic              pslverr,      // APB error
    input  wire fcl_pkg::fcl_req_t arr_req_out,  // Array request
    input  wire logic              read_inv_out, // Reads invalid
    input  wire logic [5:0]        div_out       // Divider value
);
    // ==========================================================
    // Bus and launch properties
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    ready_in_access_a: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    slverr_phase_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    // Array op lasts longer than eight cycles, so starts are spread out
    start_pulse_a: assert property (arr_req_out.start |=> !arr_req_out.start [*8])
        else $error("array start not a spaced pulse");
    once_invalid_a: assert property (
        arr_req_out.start && arr_req_out.once |-> read_inv_out)
        else $error("reads valid during once command");
    prog_align_a: assert property (
        arr_req_out.start && !arr_req_out.once |-> arr_req_out.addr[2:0] == 3'h0)
        else $error("misaligned program started");
    prog_range_a: assert property (
        arr_req_out.start && !arr_req_out.once |-> arr_req_out.addr >= FCL_PFLASH_LO)
        else $error("invalid address program started");
    div_hold_a: assert property (
        !(psel && penable && pwrite && paddr == FCL_ADDR_CLKDIV) |=> $stable(div_out))
        else $error("divider changed without write");
    rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data changed outside setup");

    prog_start_c: cover property (arr_req_out.start && !arr_req_out.once);
    once_start_c: cover property (arr_req_out.start && arr_req_out.once);
    slverr_c: cover property (pslverr);
endmodule

bind fcl_launcher fcl_launcher_props fcl_launcher_props_i (.sys_clk_in, .rst_in, .psel, .penable,
    .pwrite, .paddr, .pready, .prdata, .pslverr, .arr_req_out, .read_inv_out, .div_out);

// ===== fcl_flash_model.sv
`timescale 1ns/1ps
module fcl_flash_model
    import fcl_pkg::*;
(
    input  wire logic              sys_clk_in,  // Bus clock
    input  wire logic              rst_in,      // Sync reset
    input  wire fcl_pkg::fcl_req_t req_in,      // Array request
    input  wire logic              inj_err_in,  // Verify error to report
    input  wire logic              inj_unc_in,  // Uncorrectable to report
    output logic                   ver_err_out, // Verify error
    output logic                   ver_unc_out, // Uncorrectable error
    output logic [7:0]             starts_out,  // Starts seen
    output fcl_pkg::fcl_req_t      last_out     // Last request seen
);
    logic [7:0] cnt;
    logic       tgl;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cnt <= 8'h00;
            tgl <= 1'b0;
            starts_out <= 8'h00;
            last_out <= '0;
        end else begin
            tgl <= !tgl;
            if (req_in.start) begin
                cnt <= 8'(FCL_OP_CYCLES + 8);
                starts_out <= starts_out + 8'h01;
                last_out <= req_in;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end

    // Outside an op the lines toggle so stale values never look valid
    assign ver_err_out = (cnt != 8'h00) ? inj_err_in : tgl;
    assign ver_unc_out = (cnt != 8'h00) ? inj_unc_in : !tgl;
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import fcl_pkg::*;
    logic sys_clk_in, rst_in, psel, penable, pwrite, pready, pslverr, sv;
    logic read_inv_out, ver_err, ver_unc, inj_err, inj_unc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  div_out;
    logic [7:0]  starts, n0;
    fcl_req_t    arr_req, last;
    int          errors, comparisons, cycles;
    logic [15:0] ew0[5] = '{16'h0603, 16'h0603, 16'h0600, 16'h0603, 16'h0903};
    logic [15:0] ew1[5] = '{16'h0010, 16'h0011, 16'h0010, 16'hff00, 16'h0010};
    logic [2:0]  eix[5] = '{3'h4, 3'h5, 3'h5, 3'h5, 3'h5};
    logic [7:0]  est[5] = '{8'ha0, 8'ha0, 8'ha0, 8'h90, 8'ha0};

    fcl_launcher fcl_launcher_i (.sys_clk_in, .rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .ver_err_in(ver_err), .ver_unc_in(ver_unc),
        .arr_req_out(arr_req), .read_inv_out, .div_out);
    fcl_flash_model fcl_flash_model_i (.sys_clk_in, .rst_in, .req_in(arr_req), .inj_err_in(inj_err),
        .inj_unc_in(inj_unc), .ver_err_out(ver_err), .ver_unc_out(ver_unc), .starts_out(starts),
        .last_out(last));

    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // ==========================================================
    // Tasks
    task results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do @(posedge sys_clk_in); while (pready !== 1'b1);
        rd = prdata;
        sv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task wait_done;
        repeat (100) begin
            apb(1'b0, FCL_ADDR_STAT, 32'h0);
            if (rd[7] === 1'b1) break;
        end
        chk({31'h0, rd[7]}, 32'h1);
    endtask

    task load(input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] li);
        logic [15:0] pv;
        n0 = starts;
        for (int i = 0; i < 6; i++) begin
            pv = (i == 0) ? w0 : (i == 1) ? w1 : 16'h1111 * 16'(i);
            apb(1'b1, FCL_ADDR_INDEX, 32'(i));
            apb(1'b1, FCL_ADDR_PARAM, {16'h0, pv});
        end
        apb(1'b1, FCL_ADDR_INDEX, {29'h0, li});
        apb(1'b1, FCL_ADDR_STAT, 32'h80);
    endtask

    // Ceiling well above the less than a thousand cycles the sequence needs
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    // ==========================================================
    // Sequence
    initial begin
        {rst_in, psel, penable, pwrite, paddr, pwdata, inj_err, inj_unc} = '0;
        rst_in = 1'b1;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (20) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rdchk(FCL_ADDR_CLKDIV, 32'h00);
        rdchk(FCL_ADDR_STAT, 32'h80);
        apb(1'b1, FCL_ADDR_CLKDIV, 32'h05);
        rdchk(FCL_ADDR_CLKDIV, 32'h85);
        apb(1'b1, FCL_ADDR_CLKDIV, 32'h47);
        rdchk(FCL_ADDR_CLKDIV, 32'hc7);
        apb(1'b1, FCL_ADDR_CLKDIV, 32'h03);
        rdchk(FCL_ADDR_CLKDIV, 32'hc7);
        apb(1'b1, FCL_ADDR_MODE, 32'h1);
        rdchk(FCL_ADDR_MODE, 32'h1);
        apb(1'b1, FCL_ADDR_CLKDIV, 32'h12);
        rdchk(FCL_ADDR_CLKDIV, 32'h92);
        chk({26'h0, div_out}, 32'h12);
        apb(1'b1, FCL_ADDR_MODE, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk({31'h0, sv}, 32'h1);
        for (int i = 6; i < 8; i++) begin
            apb(1'b1, FCL_ADDR_INDEX, 32'(i));
            apb(1'b1, FCL_ADDR_PARAM, 32'h1234);
            rdchk(FCL_ADDR_PARAM, 32'h0);
        end
        apb(1'b1, FCL_ADDR_INDEX, 32'h2);
        rdchk(FCL_ADDR_INDEX, 32'h2);
        apb(1'b1, FCL_ADDR_PARAM, 32'habcd);
        rdchk(FCL_ADDR_PARAM, 32'habcd);
        apb(1'b1, FCL_ADDR_PROT, 32'h3ff00);
        rdchk(FCL_ADDR_PROT, 32'h3ff00);
        load(16'h0603, 16'h0010, 3'h5);
        rdchk(FCL_ADDR_STAT, 32'h00);
        rdchk(FCL_ADDR_PARAM, 32'h0);
        apb(1'b1, FCL_ADDR_PARAM, 32'h9999);
        wait_done();
        rdchk(FCL_ADDR_PARAM, 32'h5555);
        rdchk(FCL_ADDR_STAT, 32'h80);
        chk({14'h0, last.addr}, 32'h30010);
        chk(last.data[31:0], 32'h33332222);
        chk(last.data[63:32], 32'h55554444);
        chk({24'h0, starts}, {24'h0, n0 + 8'h01});
        for (int i = 0; i < 5; i++) begin
            load(ew0[i], ew1[i], eix[i]);
            wait_done();
            rdchk(FCL_ADDR_STAT, {24'h0, est[i]});
            chk({24'h0, starts}, {24'h0, n0});
        end
        // Valid program launched in special mode must be refused
        apb(1'b1, FCL_ADDR_MODE, 32'h1);
        rdchk(FCL_ADDR_MODE, 32'h1);
        load(16'h0603, 16'h0030, 3'h5);
        wait_done();
        rdchk(FCL_ADDR_STAT, 32'ha0);
        chk({24'h0, starts}, {24'h0, n0});
        apb(1'b1, FCL_ADDR_MODE, 32'h0);
        inj_err <= 1'b1;
        load(16'h0603, 16'h0020, 3'h5);
        wait_done();
        rdchk(FCL_ADDR_STAT, 32'h82);
        inj_unc <= 1'b1;
        load(16'h0603, 16'h0028, 3'h5);
        wait_done();
        rdchk(FCL_ADDR_STAT, 32'h83);
        inj_err <= 1'b0;
        inj_unc <= 1'b0;
        load(16'h0700, 16'h0003, 3'h5);
        repeat (3) @(negedge sys_clk_in);
        chk({31'h0, read_inv_out}, 32'h1);
        wait_done();
        rdchk(FCL_ADDR_STAT, 32'h80);
        chk({31'h0, last.once}, 32'h1);
        chk({24'h0, starts}, {24'h0, n0 + 8'h01});
        chk({31'h0, read_inv_out}, 32'h0);
        load(16'h0700, 16'h0003, 3'h5);
        wait_done();
        chk({24'h0, starts}, {24'h0, n0});
        rdchk(FCL_ADDR_STAT, 32'ha0);
        results();
    end
endmodule
